// >>> rtl/air_pkg.sv
// air_pkg: shared constants and types for the converter result read-out slave.
// assumes a single 50 MHz core clock; the link lines are sampled, not clocked on.
package air_pkg;
    // core clock rate
    localparam int unsigned CORE_CLK_HZ    = 50_000_000;
    // result stream
    localparam int unsigned RES_BITS       = 24;
    localparam int unsigned RES_BYTES      = 3;
    localparam logic [4:0]  RES_BITS_M1    = 5'h17;
    localparam logic [3:0]  BIT_ACK_SLOT   = 4'h8;
    // address strap table, upper and lower parts
    localparam logic [6:0]  ADDR_LO_HI     = 7'h14; // strap low,  lower high
    localparam logic [6:0]  ADDR_LO_FL     = 7'h15;
    localparam logic [6:0]  ADDR_FL_HI     = 7'h17;
    localparam logic [6:0]  ADDR_FL_FL     = 7'h24;
    localparam logic [6:0]  ADDR_HI_HI     = 7'h26;
    localparam logic [6:0]  ADDR_HI_FL     = 7'h27;
    // three-level strap code
    typedef enum logic [1:0] {
        STRAP_LOW,
        STRAP_FLOAT,
        STRAP_HIGH
    } air_strap_t;
    // converter sequence
    typedef enum logic [1:0] {
        SEQ_CONVERT,
        SEQ_SLEEP,
        SEQ_OUTPUT
    } air_seq_t;
    // converter result handed in by the analog/filter side
    typedef struct packed {
        logic        over;   // input at or above positive full scale
        logic        under;  // input below negative full scale
        logic [15:0] value;  // two's complement result
    } air_result_t;
endpackage : air_pkg

// >>> rtl/air_slave.sv
// air_slave: sequencer and link slave reading out the 24-bit conversion result.
// assumes the converter core pulses i_conv_done with i_result valid; the link
// lines and strap pins are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps

// Behaviour
// - after reset cycle convert, then sleep, then output, then convert again.
// - stay asleep holding the result unchanged until a read addresses it.
// - after start take seven address bits and a direction bit; match own address.
// - a match during conversion is answered by leaving the data line released.
// - a matching write is never acknowledged, whatever the state.
// - a read after conversion is acknowledged, sleep ends, result is transmitted.
// - result goes out as 24 bits, first bit first, changed at clock falls.
// - after three bytes empty the register, start converting, refuse further reads.
// - bit 23 is the sign, high for zero or positive input.
// - overrange sends 1,1 then sixteen zeros.
// - underrange sends 0,0 then sixteen ones.
// - then sixteen two's complement bits, and six trailing zeros.
// - detect start and stop as data edges while the clock is high.
// - a repeated start is handled exactly like a start.
// - each byte is eight bits and an acknowledge slot, nine clocks in all.
// - the data line is changed only while the clock is low.
// - slave only; clock is input, data line both ways.
// - lines are only pulled low, never driven high.
// - a stop during an acknowledge slot ends output and begins conversion.
// - address comes from two strap pins; a clocked lower pin reads as high.
module air_slave
    import air_pkg::*;
(
    // core clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // link lines
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe,
    // address straps
    input  wire air_strap_t  i_addr_strap_hi,
    input  wire logic        i_addr_strap_lo_or_ext_clk,
    input  wire logic        i_ext_clk_valid,
    // converter core
    input  wire logic        i_conv_done,
    input  wire air_result_t i_result,
    output logic             o_conv_start,
    output logic             o_sleep
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers: first stage is read only by the second
    logic [1:0] scl_sync_reg, sda_sync_reg, lo_sync_reg;
    logic       scl_d_reg, sda_d_reg;
    // upper strap is quasi-static; the two flops only stop metastability,
    // a strap moved in the middle of a frame is not supported
    air_strap_t hi_s1_reg, hi_s2_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            lo_sync_reg  <= 2'h0;
            hi_s1_reg    <= STRAP_LOW;
            hi_s2_reg    <= STRAP_LOW;
            scl_d_reg    <= 1'h1;
            sda_d_reg    <= 1'h1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl};
            sda_sync_reg <= {sda_sync_reg[0], i_sda};
            lo_sync_reg  <= {lo_sync_reg[0], i_addr_strap_lo_or_ext_clk | i_ext_clk_valid};
            hi_s1_reg    <= i_addr_strap_hi;
            hi_s2_reg    <= hi_s1_reg;
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line events
    wire scl_s   = scl_sync_reg[1];
    wire sda_s   = sda_sync_reg[1];
    wire scl_ris = scl_s & ~scl_d_reg;
    wire scl_fal = ~scl_s & scl_d_reg;
    wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    function automatic logic [6:0] strap_addr(input air_strap_t hi, input logic lo);
        case (hi)
            STRAP_LOW:   strap_addr = lo ? ADDR_LO_HI : ADDR_LO_FL;
            STRAP_FLOAT: strap_addr = lo ? ADDR_FL_HI : ADDR_FL_FL;
            default:     strap_addr = lo ? ADDR_HI_HI : ADDR_HI_FL;
        endcase
    endfunction : strap_addr
    wire [6:0] own_addr = strap_addr(hi_s2_reg, lo_sync_reg[1]);

    ////////////////////////////////////////////////////////////////////////
    // link state
    typedef enum logic [2:0] {
        LK_IDLE,
        LK_ADDR,
        LK_ADDR_ACK,
        LK_TX,
        LK_TX_ACK
    } air_link_t;
    air_link_t   link_reg;
    air_seq_t    seq_reg;
    logic [3:0]  bitc_reg;
    logic [7:0]  sh_in_reg;
    logic [23:0] out_reg;
    logic [4:0]  sent_reg;
    logic        ack_reg;      // address acknowledged
    logic        drive_low_reg;
    logic        conv_go_reg;

    function automatic logic [23:0] pack_result(input air_result_t r);
        if (r.over)
            pack_result = {2'h3, 16'h0000, 6'h00};
        else if (r.under)
            pack_result = {2'h0, 16'hFFFF, 6'h00};
        else
            pack_result = {~r.value[15], r.value[15], r.value, 6'h00};
    endfunction : pack_result

    // address decision, from the byte just completed
    wire [7:0] addr_byte = {sh_in_reg[6:0], sda_s};
    wire       addr_hit  = addr_byte[7:1] == own_addr;
    wire       read_ok   = addr_hit & addr_byte[0] & (seq_reg == SEQ_SLEEP);

    ////////////////////////////////////////////////////////////////////////
    // link sequencer, all decisions on sampled edges
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_reg      <= LK_IDLE;
            seq_reg       <= SEQ_CONVERT;
            bitc_reg      <= 4'h0;
            sh_in_reg     <= 8'h00;
            out_reg       <= 24'h000000;
            sent_reg      <= 5'h00;
            ack_reg       <= 1'h0;
            drive_low_reg <= 1'h0;
            conv_go_reg   <= 1'h1;
        end else begin
            conv_go_reg <= 1'h0;
            // conversion completes into sleep holding the result
            if (seq_reg == SEQ_CONVERT && i_conv_done) begin
                seq_reg <= SEQ_SLEEP;
                out_reg <= pack_result(i_result);
            end
            if (start_ev) begin
                link_reg      <= LK_ADDR;
                bitc_reg      <= 4'h0;
                drive_low_reg <= 1'h0;
            end else if (stop_ev) begin
                link_reg      <= LK_IDLE;
                drive_low_reg <= 1'h0;
                // stop during output aborts and restarts conversion
                if (seq_reg == SEQ_OUTPUT) begin
                    seq_reg     <= SEQ_CONVERT;
                    out_reg     <= 24'h000000;
                    conv_go_reg <= 1'h1;
                end
            end else begin
                case (link_reg)
                    LK_ADDR: begin
                        // eight bits then the acknowledge slot
                        if (scl_ris) begin
                            sh_in_reg <= addr_byte;
                            bitc_reg  <= bitc_reg + 4'h1;
                            ack_reg   <= read_ok;
                        end else if (scl_fal && bitc_reg == BIT_ACK_SLOT) begin
                            link_reg      <= LK_ADDR_ACK;
                            drive_low_reg <= ack_reg;
                        end
                    end
                    LK_ADDR_ACK: begin
                        if (scl_fal) begin
                            if (ack_reg) begin
                                link_reg      <= LK_TX;
                                seq_reg       <= SEQ_OUTPUT;
                                sent_reg      <= 5'h01;
                                bitc_reg      <= 4'h1;
                                // first bit placed at the falling edge
                                drive_low_reg <= ~out_reg[23];
                            end else begin
                                link_reg      <= LK_IDLE;
                                drive_low_reg <= 1'h0;
                            end
                        end
                    end
                    LK_TX: begin
                        if (scl_fal) begin
                            if (bitc_reg == BIT_ACK_SLOT) begin
                                link_reg      <= LK_TX_ACK;
                                drive_low_reg <= 1'h0;
                            end else begin
                                drive_low_reg <= ~out_reg[RES_BITS_M1 - sent_reg];
                                sent_reg      <= sent_reg + 5'h01;
                                bitc_reg      <= bitc_reg + 4'h1;
                            end
                        end
                    end
                    LK_TX_ACK: begin
                        if (scl_fal) begin
                            if (sent_reg == 5'(RES_BITS)) begin
                                link_reg    <= LK_IDLE;
                                seq_reg     <= SEQ_CONVERT;
                                out_reg     <= 24'h000000;
                                conv_go_reg <= 1'h1;
                            end else begin
                                link_reg      <= LK_TX;
                                bitc_reg      <= 4'h1;
                                drive_low_reg <= ~out_reg[RES_BITS_M1 - sent_reg];
                                sent_reg      <= sent_reg + 5'h01;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open drain, only ever pulls low
    assign o_sda        = 1'h0;
    assign o_sda_oe     = drive_low_reg;
    assign o_conv_start = conv_go_reg;
    assign o_sleep      = seq_reg == SEQ_SLEEP;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_no_high_drive;
        @(posedge i_core_clk) disable iff (!i_rst_n) o_sda_oe |-> o_sda == 1'h0;
    endproperty
    a_no_high_drive: assert property (p_no_high_drive) else $error("sda driven high");
    property p_conv_nak;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (link_reg == LK_ADDR_ACK && seq_reg == SEQ_CONVERT) |-> !o_sda_oe;
    endproperty
    a_conv_nak: assert property (p_conv_nak) else $error("ack during conversion");
    property p_write_nak;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            (scl_ris && link_reg == LK_ADDR && bitc_reg == 4'h7 && !sda_s) |=> !ack_reg;
    endproperty
    a_write_nak: assert property (p_write_nak) else $error("write acknowledged");
    property p_change_scl_low;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            $changed(o_sda_oe) && !start_ev && !stop_ev |-> !scl_s;
    endproperty
    a_change_scl_low: assert property (p_change_scl_low) else $error("sda moved, scl high");
    property p_sleep_hold;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            seq_reg == SEQ_SLEEP && $past(seq_reg == SEQ_SLEEP) |-> $stable(out_reg);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("result changed in sleep");
    property p_stop_abort;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            stop_ev && seq_reg == SEQ_OUTPUT |=> seq_reg == SEQ_CONVERT && o_conv_start;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
    property p_tail_zero;
        @(posedge i_core_clk) disable iff (!i_rst_n) out_reg[5:0] == 6'h00;
    endproperty
    a_tail_zero: assert property (p_tail_zero) else $error("tail bits not zero");
    property p_ack_release;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            link_reg == LK_TX_ACK |-> !o_sda_oe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("sda held in ack slot");
    property p_done_sleep;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            seq_reg == SEQ_CONVERT && i_conv_done |=> o_sleep;
    endproperty
    a_done_sleep: assert property (p_done_sleep) else $error("no sleep after conversion");
    property p_ack_read_sleep;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            link_reg == LK_ADDR_ACK && o_sda_oe
                |-> seq_reg == SEQ_SLEEP && sh_in_reg == {own_addr, 1'h1};
    endproperty
    a_ack_read_sleep: assert property (p_ack_read_sleep) else $error("bad acknowledge");
    property p_full_read;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            link_reg == LK_TX_ACK && scl_fal && sent_reg == 5'(RES_BITS)
                |=> o_conv_start && seq_reg == SEQ_CONVERT && out_reg == 24'h000000;
    endproperty
    a_full_read: assert property (p_full_read) else $error("read end did not restart");
    property p_bit_order;
        @(posedge i_core_clk) disable iff (!i_rst_n)
            $changed(sent_reg) |-> o_sda_oe == !out_reg[5'(RES_BITS) - sent_reg];
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("result bit out of order");
endmodule : air_slave

// >>> tb/air_mstr.sv
// air_mstr: behavioural link master that frames reads and writes.
// assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module air_mstr (
    // link lines
    output logic      o_scl,
    output logic      o_sda_pull,
    input  wire logic i_sda
);
    // quarter period; the bench link runs well past the 400 kbit/s
    // ceiling on purpose, the slave needs only a few core samples a phase
    localparam time QTR = 40ns;

    // clock stands high and data released while idle
    initial begin
        o_scl      = 1'b1;
        o_sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // start, also used as repeated start
    // data moves a quarter period after the clock fell, never with it
    task automatic start_cond();
        #QTR o_sda_pull <= 1'b0;
        #QTR o_scl <= 1'b1;
        #QTR o_sda_pull <= 1'b1;
        #QTR o_scl <= 1'b0;
    endtask : start_cond

    // stop, from a low clock, also inside an ack slot
    task automatic stop_cond();
        #QTR o_sda_pull <= 1'b1;
        #QTR o_scl <= 1'b1;
        #QTR o_sda_pull <= 1'b0;
        #QTR;
    endtask : stop_cond

    // data set mid-low, read while the clock is high
    task automatic shift(input int n, input logic [8:0] tx, output logic [8:0] rx);
        rx = '1;
        for (int i = 8; i > 8 - n; i--) begin
            #QTR o_sda_pull <= ~tx[i];
            #QTR o_scl <= 1'b1;
            #QTR rx[i] = i_sda;
            #QTR o_scl <= 1'b0;
        end
    endtask : shift
endmodule : air_mstr

// >>> tb/testbench.sv
// testbench: link master and converter stand-in around the read-out slave.
// assumes the package and slave compiled first; data line pulled up.
`timescale 1ns/1ps
module testbench
    import air_pkg::*;
();
    localparam logic [6:0] OWN_ADDR = 7'h14;
    localparam int         CONV_CYC = 400;
    logic        core_clk;
    logic        rst_n;
    logic        scl;
    logic        sda_pull;
    logic        sda_oe;
    logic        sda_out;
    wire         sda_line;
    air_strap_t  strap_hi;
    logic        strap_lo;
    logic        ext_ok;
    logic        conv_done = 1'b0;
    air_result_t result;
    logic        conv_start;
    logic        sleep_st;
    int          conv_cnt = 0;
    int          starts = 0;
    int          fails = 0;
    int          samples_checked = 0;

    // wired-and data line, released level is high
    assign sda_line = ~(sda_oe | sda_pull);

    air_slave i_dut (
        .i_core_clk                 (core_clk),
        .i_rst_n                    (rst_n),
        .i_scl                      (scl),
        .i_sda                      (sda_line),
        .o_sda                      (sda_out),
        .o_sda_oe                   (sda_oe),
        .i_addr_strap_hi            (strap_hi),
        .i_addr_strap_lo_or_ext_clk (strap_lo),
        .i_ext_clk_valid            (ext_ok),
        .i_conv_done                (conv_done),
        .i_result                   (result),
        .o_conv_start               (conv_start),
        .o_sleep                    (sleep_st)
    );

    air_mstr i_mst (
        .o_scl      (scl),
        .o_sda_pull (sda_pull),
        .i_sda      (sda_line)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // converter stand-in; long enough to outlast a refused re-read
    always @(posedge core_clk) begin
        conv_done <= (conv_cnt == 1);
        conv_cnt  <= conv_start ? CONV_CYC : (conv_cnt > 0 ? conv_cnt - 1 : 0);
        if (rst_n && conv_start)
            starts <= starts + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // bounded wait for the sleep state
    task automatic wait_sleep();
        int n;
        n = 0;
        while (sleep_st !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 5000) begin
            fails++;
            $display("ERROR %0t sleep never reached", $time);
            tally_and_finish();
        end
    endtask : wait_sleep

    task automatic addr(input logic [6:0] a, input logic rw, output logic ack);
        logic [8:0] rx;
        i_mst.start_cond();
        i_mst.shift(9, {a, rw, 1'b1}, rx);
        ack = ~rx[0];
    endtask : addr

    ////////////////////////////////////////////////////////////////////////
    task automatic t_busy();
        logic ack;
        addr(OWN_ADDR, 1'b1, ack);
        i_mst.stop_cond();
        check(24'(ack), 24'h0, "read while converting");
        addr(OWN_ADDR, 1'b0, ack);
        i_mst.stop_cond();
        check(24'(ack), 24'h0, "write while converting");
        check(24'(sleep_st), 24'h0, "converting first");
        check(24'(sda_out), 24'h0, "drives low only");
    endtask : t_busy

    // results with sign, overrange, underrange and zero
    task automatic t_results();
        air_result_t tbl [5] = '{'{1'b0, 1'b0, 16'h1234}, '{1'b0, 1'b0, 16'h8001},
                                 '{1'b1, 1'b0, 16'h5A5A}, '{1'b0, 1'b1, 16'h5A5A},
                                 '{1'b0, 1'b0, 16'h0000}};
        logic [23:0] exp_q;
        logic [23:0] got;
        logic [8:0]  rx;
        logic        ack;
        int          s0;
        for (int k = 0; k < 5; k++) begin
            if (tbl[k].over)
                exp_q = 24'hC00000;
            else if (tbl[k].under)
                exp_q = 24'h3FFFC0;
            else
                exp_q = {~tbl[k].value[15], tbl[k].value[15], tbl[k].value, 6'h00};
            @(posedge core_clk);
            result <= tbl[k];
            wait_sleep();
            @(posedge core_clk);
            result <= ~tbl[k];
            repeat (50) @(posedge core_clk);
            check(24'(sleep_st), 24'h1, "sleep held");
            addr(OWN_ADDR, 1'b0, ack);
            i_mst.stop_cond();
            check(24'(ack), 24'h0, "write in sleep");
            s0 = starts;
            addr(OWN_ADDR, 1'b1, ack);
            check(24'(ack), 24'h1, "read acknowledged");
            for (int b = 0; b < 3; b++) begin
                i_mst.shift(9, {8'hFF, b == 2}, rx);
                got = {got[15:0], rx[8:1]};
            end
            check(24'(sleep_st), 24'h0, "sleep left");
            check(got, exp_q, "result stream");
            addr(OWN_ADDR, 1'b1, ack);
            i_mst.stop_cond();
            check(24'(ack), 24'h0, "re-read refused");
            check(24'(starts - s0), 24'h1, "new conversion");
        end
    endtask : t_results

    // every strap pairing, then abort by a stop in the ack slot
    task automatic t_straps();
        air_strap_t hi_tbl [7] = '{STRAP_LOW, STRAP_LOW, STRAP_FLOAT, STRAP_FLOAT,
                                   STRAP_HIGH, STRAP_HIGH, STRAP_FLOAT};
        logic [6:0] a_tbl [7] = '{7'h14, 7'h15, 7'h17, 7'h24, 7'h26, 7'h27, 7'h17};
        logic [8:0] rx;
        logic       ack;
        int         s0;
        for (int k = 0; k < 7; k++) begin
            @(posedge core_clk);
            strap_hi <= hi_tbl[k];
            strap_lo <= (k % 2 == 0) && (k != 6);
            ext_ok   <= (k == 6);
            wait_sleep();
            addr(a_tbl[k] ^ 7'h01, 1'b1, ack);
            i_mst.stop_cond();
            check(24'(ack), 24'h0, "foreign address");
            s0 = starts;
            addr(a_tbl[k], 1'b1, ack);
            check(24'(ack), 24'h1, "strap address");
            i_mst.shift(8, 9'h1FF, rx);
            i_mst.stop_cond();
            repeat (10) @(posedge core_clk);
            check(24'(starts - s0), 24'h1, "abort restarts");
            check(24'(sleep_st), 24'h0, "abort ends output");
        end
    endtask : t_straps

    initial begin
        rst_n     = 1'b0;
        strap_hi  = STRAP_LOW;
        strap_lo  = 1'b1;
        ext_ok    = 1'b0;
        result    = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_busy();
        t_results();
        t_straps();
        tally_and_finish();
    end
endmodule : testbench
